// File: logic/host_bus_cfg.svh
// Function
// - Two static style pins pick split-strobe, split-direction or multiplexed bus; one code reserved.
// - Multiplexed mode shares eight pins for address in, then data either way.
// - Address latch strobe high captures the multiplexed address, held for the cycle.
// - Transfers happen only while the active-low chip select is low.
// - Strobe styles: read strobe low reads, write strobe low writes.
// - Direction style: read-not-write high reads, low writes.
// - Direction style: active-low data strobe on the write pin qualifies transfers.
// - Strobe styles: ready low while unable to complete, high when complete.
// - Direction style: transfer acknowledge low once read data valid or write accepted.
// - Ready or acknowledge pin floats whenever not actively driven.
// - Strobe styles: interrupt pin high on an alarm whose mask bit is 0.
// - Direction style: open-drain interrupt pin driven low on an unmasked alarm.
// - Split styles take address on dedicated inputs, data on separate bidirectional bus.
// - Device reset input low returns all state to defaults.
// - Output float input low releases every output and bidirectional pin.
`ifndef HOST_BUS_CFG_SVH
`define HOST_BUS_CFG_SVH

// Bus style selection codes, read as {sel_1, sel_0}.
`define STYLE_CODE_SPLIT_DIR   2'h0
`define STYLE_CODE_RESERVED    2'h1
`define STYLE_CODE_SPLIT_STB   2'h2
`define STYLE_CODE_MUXED       2'h3

// Clock and timing figures.
`define CLK_PERIOD_NS          5
`define REFCLK_TIMEOUT_NS      500
`define REFCLK_TIMEOUT_CYC     (`REFCLK_TIMEOUT_NS / `CLK_PERIOD_NS)
`define RESET_MIN_NS           150
`define RESET_MIN_CYC          ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Reset values.
`define ADDR_RESET             8'h00
`define DATA_RESET             8'h00
`define IDLE_CNT_RESET         8'h00

`endif

// File: logic/host_bus_interface.sv
`timescale 1ns/100ps
`include "host_bus_cfg.svh"
module host_bus_interface (
    // Clock, reset and enable.
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic        clk_en_i,
    input  wire logic        device_reset_n_i,
    // Static configuration and board control.
    input  wire logic        bus_style_sel_0_i,
    input  wire logic        bus_style_sel_1_i,
    input  wire logic        output_float_n_i,
    input  wire logic        alarm_fill_refclk_i,
    // Host bus strobes.
    input  wire logic        chip_select_n_i,
    input  wire logic        rd_or_rnw_i,
    input  wire logic        write_or_data_strobe_i,
    input  wire logic        addr_latch_i,
    input  wire logic [7:0]  addr_i,
    // Shared data or address/data pins.
    input  wire logic [7:0]  ad_i,
    output logic      [7:0]  ad_o,
    output logic      [7:0]  ad_oe_o,
    // Ready or transfer acknowledge pin.
    output logic             ready_o,
    output logic             ready_oe_o,
    // Open-drain interrupt pin.
    output logic             irq_o,
    output logic             irq_oe_o,
    // Internal register access side.
    output logic      [7:0]  reg_addr_o,
    output logic      [7:0]  reg_wdata_o,
    output logic             reg_rd_o,
    output logic             reg_wr_o,
    input  wire logic [7:0]  reg_rdata_i,
    input  wire logic        reg_ack_i,
    // Alarm sources and their mask bits.
    input  wire logic [7:0]  alarm_i,
    input  wire logic [7:0]  alarm_mask_i
);
    import host_bus_pkg::*;

    // Last count before the reference clock is declared dead.
    localparam logic [7:0] TIMEOUT_LAST = 8'(`REFCLK_TIMEOUT_CYC - 1);

    // Map the two selection pins onto a style.
    // The reserved code decodes to a style of its own so nothing downstream reacts to it.
    function automatic bus_style_t decode_style(input logic [1:0] code);
        bus_style_t s;
        unique case (code)
            `STYLE_CODE_SPLIT_DIR: s = STYLE_SPLIT_DIR;
            `STYLE_CODE_RESERVED:  s = STYLE_RESERVED;
            `STYLE_CODE_SPLIT_STB: s = STYLE_SPLIT_STB;
            `STYLE_CODE_MUXED:     s = STYLE_MUXED;
        endcase
        return s;
    endfunction : decode_style

    // Registered state, its next value and the local decode of the pins.
    hbi_state_t  s_ff;
    hbi_state_t  nxt_s;
    bus_style_t  style;
    logic        rst;
    logic        dir_style;
    logic        stb_style;
    logic        rd_req;
    logic        wr_req;
    logic        strobe_on;
    logic        cycle_go;

    // The pin stage turns requests into levels and enables. Keeping it apart
    // puts all float and polarity handling in one place, so the sequencer
    // never needs to know which bus style owns which pin level.
    pin_drive_if pd ();

    pin_output_stage u_stage (
        .pd (pd.stage)
    );

    // Either reset source clears everything; the board keeps the pin low long enough.
    assign rst = reset_i | ~device_reset_n_i;

    // The selection pins are static; changing them during an access is not supported.
    assign style     = decode_style({bus_style_sel_1_i, bus_style_sel_0_i});
    assign dir_style = (style == STYLE_SPLIT_DIR);
    assign stb_style = (style == STYLE_SPLIT_STB) || (style == STYLE_MUXED);

    // Direction style: data strobe on the write pin, direction on the read pin.
    // Strobe styles: separate active-low read and write strobes.
    assign rd_req = dir_style ? (~write_or_data_strobe_i & rd_or_rnw_i)
                              : (stb_style & ~rd_or_rnw_i);
    assign wr_req = dir_style ? (~write_or_data_strobe_i & ~rd_or_rnw_i)
                              : (stb_style & ~write_or_data_strobe_i);
    assign strobe_on = ~chip_select_n_i & (rd_req | wr_req);
    // A dead reference clock holds the host in wait states rather than faking a transfer.
    assign cycle_go  = strobe_on & s_ff.alive;

    // Next-state logic for the whole interface.
    // An access walks through three states. In idle the sequencer watches for a
    // selected strobe and, once the reference clock is known to run, takes the
    // address and write data from the pins and fires a one-cycle pulse towards
    // the register file. In wait it holds the host off until the register file
    // answers, capturing read data on that answer. In done it shows completion
    // on the ready or acknowledge pin and stays there until the host lets go of
    // its strobe or select, so a long strobe can never start a second access.
    // A strobe that ends early is not an abort: the register pulse has already
    // gone out, so the sequencer still waits for the answer before idling.
    // The register side has no timeout of its own; a register file that never
    // answers leaves the host in wait states, which keeps a failure visible.
    always_comb begin
        nxt_s          = s_ff;
        nxt_s.rd_pulse = 1'b0;
        nxt_s.wr_pulse = 1'b0;

        // Reference clock activity watch; inputs are synchronous so no synchroniser.
        // The watch counts cycles without a level change on the reference clock.
        // After the limit the interface stops starting accesses, since transfers
        // depend on that clock elsewhere in the device. The counter saturates, so
        // a long stop costs nothing more than a short one.
        nxt_s.refclk_q = alarm_fill_refclk_i;
        if (alarm_fill_refclk_i != s_ff.refclk_q) begin
            nxt_s.idle_cnt = `IDLE_CNT_RESET;
            nxt_s.alive    = 1'b1;
        end else if (s_ff.idle_cnt == TIMEOUT_LAST) begin
            nxt_s.alive    = 1'b0;
        end else begin
            nxt_s.idle_cnt = s_ff.idle_cnt + 8'h01;
        end

        // The multiplexed address is caught while the latch strobe is high.
        // The latch follows the pins while the strobe stays high and freezes when it
        // falls; once an access is under way it stays frozen as well.
        if ((style == STYLE_MUXED) && addr_latch_i && (s_ff.state == ST_IDLE)) begin
            nxt_s.latched_addr = ad_i;
        end

        unique case (s_ff.state)
            ST_IDLE: begin
                if (cycle_go) begin
                    // Split styles use the dedicated address inputs.
                    nxt_s.addr     = (style == STYLE_MUXED) ? s_ff.latched_addr : addr_i;
                    nxt_s.wdata    = ad_i;
                    nxt_s.is_read  = rd_req;
                    nxt_s.rd_pulse = rd_req;
                    nxt_s.wr_pulse = ~rd_req;
                    nxt_s.state    = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Wait for the register file; the host is held off meanwhile.
                // Write data was captured at take, so only reads need the answer's data.
                if (reg_ack_i) begin
                    if (s_ff.is_read) begin
                        nxt_s.rdata = reg_rdata_i;
                    end
                    nxt_s.state = ST_DONE;
                end
            end
            ST_DONE: begin
                // Hold completion until the host ends its strobe, so one access per cycle.
                if (!strobe_on) begin
                    nxt_s.state = ST_IDLE;
                end
            end
            default: begin
                // The fourth state code is never entered; recover to idle if it appears.
                nxt_s.state = ST_IDLE;
            end
        endcase
    end

    // State register, frozen while the clock enable is low.
    // Reset takes priority over the enable, so a frozen interface can still be cleared.
    always_ff @(posedge clock_i) begin
        if (rst) begin
            s_ff <= '{state:        ST_IDLE,
                      latched_addr: `ADDR_RESET,
                      addr:         `ADDR_RESET,
                      wdata:        `DATA_RESET,
                      rdata:        `DATA_RESET,
                      is_read:      1'b0,
                      rd_pulse:     1'b0,
                      wr_pulse:     1'b0,
                      refclk_q:     1'b0,
                      idle_cnt:     `IDLE_CNT_RESET,
                      alive:        1'b0};
        end else if (clk_en_i) begin
            s_ff <= nxt_s;
        end
    end

    // Requests to the pin stage.
    assign pd.style         = style;
    assign pd.float_n       = output_float_n_i;
    // Ready goes low in the very cycle the strobe arrives, before the access starts.
    assign pd.access_active = strobe_on | (s_ff.state != ST_IDLE);
    assign pd.access_done   = (s_ff.state == ST_DONE);
    assign pd.drive_data    = ~chip_select_n_i & rd_req;
    // An alarm counts only while its mask bit is 0.
    assign pd.irq_req       = |(alarm_i & ~alarm_mask_i);

    // Pin outputs.
    // Enables are combinational so the data pins float in the same cycle the host
    // lets go, which avoids fighting the host on its next bus cycle; the ready pin
    // floats once the sequencer is back in idle. Read data comes from the register,
    // so the pins never show a half-updated value.
    assign ad_o       = s_ff.rdata;
    assign ad_oe_o    = {8{pd.data_oe}};
    assign ready_o    = pd.ready_lvl;
    assign ready_oe_o = pd.ready_oe;
    assign irq_o      = pd.irq_lvl;
    assign irq_oe_o   = pd.irq_oe;

    // Register side outputs, all from flops.
    // The register file sees only registered strobes, never glitches from the
    // host pins, at the cost of one cycle of latency on every access.
    assign reg_addr_o  = s_ff.addr;
    assign reg_wdata_o = s_ff.wdata;
    assign reg_rd_o    = s_ff.rd_pulse;
    assign reg_wr_o    = s_ff.wr_pulse;
endmodule : host_bus_interface

// File: logic/host_bus_pkg.sv
package host_bus_pkg;

    // Decoded bus style.
    typedef enum logic [1:0] {
        STYLE_SPLIT_DIR,
        STYLE_RESERVED,
        STYLE_SPLIT_STB,
        STYLE_MUXED
    } bus_style_t;

    // Access sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_DONE
    } acc_state_t;

    // Complete state of the bus interface.
    typedef struct packed {
        acc_state_t  state;
        logic [7:0]  latched_addr;
        logic [7:0]  addr;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
        logic        is_read;
        logic        rd_pulse;
        logic        wr_pulse;
        logic        refclk_q;
        logic [7:0]  idle_cnt;
        logic        alive;
    } hbi_state_t;

endpackage : host_bus_pkg

// File: logic/pin_drive_if.sv
`timescale 1ns/100ps
interface pin_drive_if;
    import host_bus_pkg::*;

    host_bus_pkg::bus_style_t style;
    logic                     float_n;
    logic                     access_active;
    logic                     access_done;
    logic                     drive_data;
    logic                     irq_req;
    logic                     ready_lvl;
    logic                     ready_oe;
    logic                     irq_lvl;
    logic                     irq_oe;
    logic                     data_oe;

    // The sequencer states what it wants; the stage decides pin levels.
    modport ctrl  (output style, float_n, access_active, access_done, drive_data, irq_req,
                   input  ready_lvl, ready_oe, irq_lvl, irq_oe, data_oe);
    modport stage (input  style, float_n, access_active, access_done, drive_data, irq_req,
                   output ready_lvl, ready_oe, irq_lvl, irq_oe, data_oe);
endinterface : pin_drive_if

// File: logic/pin_output_stage.sv
`timescale 1ns/100ps
module pin_output_stage (
    pin_drive_if.stage pd
);
    import host_bus_pkg::*;

    logic dir_style;
    logic stb_style;

    // Style classes; the reserved code falls in neither, so nothing drives there.
    assign dir_style = (pd.style == STYLE_SPLIT_DIR);
    assign stb_style = (pd.style == STYLE_SPLIT_STB) || (pd.style == STYLE_MUXED);

    // Ready is high on completion, acknowledge is low on completion.
    assign pd.ready_lvl = dir_style ? ~pd.access_done : pd.access_done;
    // Only driven during an access; the float input overrides everything.
    assign pd.ready_oe  = pd.float_n & pd.access_active & (dir_style | stb_style);

    // Open drain: a high is the pull-up, so only a low is ever driven.
    assign pd.irq_lvl = 1'b0;
    assign pd.irq_oe  = pd.float_n & (dir_style ? pd.irq_req
                                                : (stb_style & ~pd.irq_req));

    // Data pins follow the selected read only.
    assign pd.data_oe = pd.float_n & pd.drive_data;
endmodule : pin_output_stage

// File: sim/host_bus_interface_checker.sv
`timescale 1ns/100ps
module host_bus_interface_checker (
    // Clock, reset, style and board control.
    input wire logic       clock_i, reset_i, device_reset_n_i, output_float_n_i,
    input wire logic       bus_style_sel_0_i, bus_style_sel_1_i, chip_select_n_i,
    // Host pins, register side and alarms.
    input wire logic [7:0] ad_i, addr_i, ad_oe_o, reg_addr_o, reg_wdata_o,
    input wire logic [7:0] alarm_i, alarm_mask_i,
    input wire logic       ready_o, ready_oe_o, irq_oe_o, reg_rd_o, reg_wr_o, reg_ack_i
);
    logic [1:0] st;
    logic       unm;
    // Decoded style and the unmasked alarm summary.
    assign st  = {bus_style_sel_1_i, bus_style_sel_0_i};
    assign unm = |(alarm_i & ~alarm_mask_i);
    default clocking dc @(posedge clock_i); endclocking
    default disable iff (reset_i);
    float_off_a: assert property (
        !output_float_n_i |-> ad_oe_o == 8'h00 && !ready_oe_o && !irq_oe_o)
        else $error("pins driven while floated");
    data_sel_a: assert property (
        ad_oe_o != 8'h00 |-> !chip_select_n_i && output_float_n_i)
        else $error("data driven without select");
    take_sel_a: assert property (
        (reg_rd_o || reg_wr_o) |-> $past(chip_select_n_i) == 1'h0)
        else $error("access taken without select");
    wait_rdy_a: assert property (
        (reg_rd_o || reg_wr_o) && output_float_n_i && st[1] |-> ready_oe_o && !ready_o)
        else $error("ready not low while waiting");
    wait_ack_a: assert property (
        (reg_rd_o || reg_wr_o) && output_float_n_i && st == 2'h0 |-> ready_oe_o && ready_o)
        else $error("acknowledge not high while waiting");
    done_rdy_a: assert property (
        (reg_rd_o || reg_wr_o) ##1 (reg_ack_i && output_float_n_i)
        |=> ready_oe_o && ready_o == st[1])
        else $error("completion not signalled");
    irq_stb_a: assert property (
        st[1] && output_float_n_i |-> irq_oe_o == !unm)
        else $error("interrupt level wrong in strobe style");
    irq_dir_a: assert property (
        st == 2'h0 && output_float_n_i |-> irq_oe_o == unm)
        else $error("interrupt level wrong in direction style");
    rsvd_off_a: assert property (
        st == 2'h1 |-> !ready_oe_o && !irq_oe_o && !reg_rd_o && !reg_wr_o)
        else $error("activity in reserved style");
    wdata_a: assert property (
        reg_wr_o |-> reg_wdata_o == $past(ad_i))
        else $error("write data not taken from bus");
    addr_a: assert property (
        (reg_rd_o || reg_wr_o) && st != 2'h3 |-> reg_addr_o == $past(addr_i))
        else $error("address not taken from address pins");
    dev_rst_a: assert property (
        !device_reset_n_i |=> !reg_rd_o && !reg_wr_o)
        else $error("access pulse during device reset");
    cover property (reg_rd_o ##1 reg_ack_i);
    cover property (reg_wr_o && st == 2'h3);
    cover property (!output_float_n_i && !chip_select_n_i);
endmodule : host_bus_interface_checker

bind host_bus_interface host_bus_interface_checker u_host_bus_interface_checker (
    .clock_i, .reset_i, .device_reset_n_i, .output_float_n_i, .bus_style_sel_0_i,
    .bus_style_sel_1_i, .chip_select_n_i, .ad_i, .addr_i, .ad_oe_o, .reg_addr_o,
    .reg_wdata_o, .alarm_i, .alarm_mask_i, .ready_o, .ready_oe_o, .irq_oe_o, .reg_rd_o,
    .reg_wr_o, .reg_ack_i);

// File: sim/host_bus_interface_tb_top.sv
`timescale 1ns/100ps
module host_bus_interface_tb_top;
    logic       clock_i = 0, reset_i = 1, rst_n = 0, flt_n = 1, refclk = 0, reg_ack_i = 0;
    logic       ready_o, ready_oe_o, irq_o, irq_oe_o, reg_rd_o, reg_wr_o, cs_n, rnw, wstb_n, ale;
    logic       clk_en = 1;
    logic [1:0] sel = 2'h2;
    logic [7:0] alarm_i = 0, alarm_mask_i = 8'hFF, bus, ad_o, ad_oe_o, reg_addr_o;
    logic [7:0] reg_wdata_o, reg_rdata_i, h_addr, h_d, mem [256];
    int         err_total = 0, cmp_count = 0, pulses = 0;
    // The device wins the shared wire only while it enables it.
    assign bus = (ad_oe_o != 8'h00) ? ad_o : h_d;
    assign reg_rdata_i = mem[reg_addr_o];
    initial forever #2.5 clock_i = ~clock_i;
    // Reference clock keeps running so accesses are started.
    always @(posedge clock_i) refclk <= #1 ~refclk;
    // Register store answers every pulse on the next cycle.
    always @(posedge clock_i) begin
        reg_ack_i <= #1 reg_rd_o | reg_wr_o;
        if (reg_wr_o) mem[reg_addr_o] <= reg_wdata_o;
        if (reg_rd_o | reg_wr_o) pulses++;
    end
    host_bus_interface u_host_bus_interface (.clock_i, .reset_i, .clk_en_i(clk_en),
        .device_reset_n_i(rst_n), .bus_style_sel_0_i(sel[0]), .bus_style_sel_1_i(sel[1]),
        .output_float_n_i(flt_n), .alarm_fill_refclk_i(refclk), .chip_select_n_i(cs_n),
        .rd_or_rnw_i(rnw), .write_or_data_strobe_i(wstb_n), .addr_latch_i(ale), .addr_i(h_addr),
        .ad_i(bus), .ad_o, .ad_oe_o, .ready_o, .ready_oe_o, .irq_o, .irq_oe_o, .reg_addr_o,
        .reg_wdata_o, .reg_rd_o, .reg_wr_o, .reg_rdata_i, .reg_ack_i, .alarm_i,
        .alarm_mask_i);
    host_model u_host_model (.clock_i, .style_i(sel), .ready_i(ready_o),
        .ready_oe_i(ready_oe_o), .bus_i(bus), .cs_n_o(cs_n), .rnw_o(rnw), .wstb_n_o(wstb_n),
        .ale_o(ale), .addr_o(h_addr), .d_o(h_d));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up;
        $display("Counts: %0d compares, %0d errors", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    // Write then read back one place in the given style.
    task automatic t_rw(input logic [1:0] st);
        logic [7:0] r;
        logic       ok;
        sel = st;
        u_host_model.access(1'h0, {6'h30, st}, {st, 6'h2B}, r, ok);
        chk({7'h0, ok}, 8'h01);
        chk(mem[{6'h30, st}], {st, 6'h2B});
        u_host_model.access(1'h1, {6'h30, st}, 8'h00, r, ok);
        chk({7'h0, ok}, 8'h01);
        chk(r, {st, 6'h2B});
        #1;
        chk(ad_oe_o, 8'h00);
        if (ok !== 1'h1) wrap_up();
        $display("test rw style %0d done", st);
    endtask : t_rw
    // Deselected and reserved-style strobes must start nothing.
    task automatic t_sel;
        int p;
        p = pulses;
        u_host_model.bare(1'h1);
        sel = 2'h1;
        u_host_model.bare(1'h0);
        sel = 2'h2;
        chk(pulses[7:0], p[7:0]);
        $display("test select done");
    endtask : t_sel
    // Pin level against mask in both interrupt polarities.
    task automatic t_irq;
        logic pin;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_i);
            #1;
            sel = i[1] ? 2'h2 : 2'h0;
            alarm_i = 8'h10;
            alarm_mask_i = i[0] ? 8'hEF : 8'h10;
            #1;
            pin = irq_oe_o ? irq_o : 1'h1;
            chk({7'h0, pin}, {7'h0, i[0] == i[1]});
        end
        $display("test irq done");
    endtask : t_irq
    // Float while the interrupt pin would drive and a read strobe is held.
    task automatic t_float;
        @(posedge clock_i);
        #1;
        flt_n        = 1'h0;
        sel          = 2'h2;
        alarm_mask_i = 8'hFF;
        fork
            u_host_model.bare(1'h0);
            begin
                repeat (10) @(posedge clock_i);
                #2;
                chk({5'h0, ad_oe_o[0], ready_oe_o, irq_oe_o}, 8'h00);
            end
        join
        flt_n = 1'h1;
        #1;
        chk({7'h0, irq_oe_o}, 8'h01);
        $display("test float done");
    endtask : t_float
    // A frozen clock enable holds a strobe in wait; one access follows the thaw.
    task automatic t_hold;
        int p;
        p = pulses;
        repeat (2) @(posedge clock_i);
        #1 clk_en = 1'h0;
        fork
            u_host_model.bare(1'h0);
            begin
                repeat (20) @(posedge clock_i);
                chk(pulses[7:0], p[7:0]);
                chk({6'h0, ready_oe_o, ready_o}, 8'h02);
                #1 clk_en = 1'h1;
            end
        join
        chk(pulses[7:0], 8'(p + 1));
        $display("test hold done");
    endtask : t_hold
    // Device reset in mid-access clears the completion.
    task automatic t_reset;
        fork
            u_host_model.bare(1'h0);
            begin
                repeat (6) @(posedge clock_i);
                #1 rst_n = 1'h0;
                repeat (30) @(posedge clock_i);
                #1 rst_n = 1'h1;
                chk({7'h0, ready_o}, 8'h00);
            end
        join
        $display("test reset done");
    endtask : t_reset
    initial begin
        repeat (6) @(posedge clock_i);
        #1 reset_i = 1'h0;
        repeat (24) @(posedge clock_i);
        #1 rst_n = 1'h1;
        repeat (4) @(posedge clock_i);
        t_rw(2'h2);
        t_rw(2'h0);
        t_rw(2'h3);
        t_sel();
        t_irq();
        t_float();
        t_hold();
        t_reset();
        wrap_up();
    end
    initial begin
        #100000;
        err_total++;
        wrap_up();
    end
endmodule : host_bus_interface_tb_top

// File: sim/host_model.sv
`timescale 1ns/100ps
module host_model (
    // Clock, style and device answer.
    input  wire logic       clock_i,
    input  wire logic [1:0] style_i,
    input  wire logic       ready_i,
    input  wire logic       ready_oe_i,
    input  wire logic [7:0] bus_i,
    // Host strobes, address and data drive.
    output logic            cs_n_o,
    output logic            rnw_o,
    output logic            wstb_n_o,
    output logic            ale_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      d_o
);
    // Idle levels; the latch strobe rests high so the multiplexed address follows the pins.
    initial begin
        {cs_n_o, rnw_o, wstb_n_o, ale_o} = 4'hF;
        addr_o = 8'h00;
        d_o    = 8'h00;
    end
    // Released lines show the inverse so a stale value cannot pass.
    task automatic release_bus;
        #1;
        {cs_n_o, rnw_o, wstb_n_o, ale_o} = 4'hF;
        addr_o = ~addr_o;
        d_o    = ~d_o;
    endtask : release_bus
    // One register access, held until the device signals completion.
    task automatic access(input logic rd, input logic [7:0] a, w,
                          output logic [7:0] r, output logic ok);
        @(posedge clock_i);
        #1;
        addr_o = a;
        d_o    = (style_i == 2'h3) ? a : w;
        if (style_i == 2'h3) begin
            @(posedge clock_i);
            #1;
            ale_o = 1'h0;
            d_o   = rd ? ~a : w;
        end
        cs_n_o = 1'h0;
        rnw_o  = (style_i == 2'h0) ? rd : !rd;
        wstb_n_o = (style_i != 2'h0) && rd;
        ok     = 1'h0;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge clock_i);
            ok = ready_oe_i && ready_i === (style_i != 2'h0);
        end
        r = bus_i;
        release_bus();
    endtask : access
    // A read strobe held for a fixed time with a chosen select level.
    task automatic bare(input logic c);
        @(posedge clock_i);
        #1;
        cs_n_o = c;
        rnw_o  = 1'h0;
        repeat (40) @(posedge clock_i);
        release_bus();
    endtask : bare
endmodule : host_model
